// [include/capture_timer_pkg.sv]
// Package of offsets, fields and constants for the 16-bit capture timer
package capture_timer_pkg;
	// Register indices; the bus byte address is four times the index
	localparam logic [7:0] IDX_MODE = 8'ha0;
	localparam logic [7:0] IDX_CNT_LO = 8'ha1;
	localparam logic [7:0] IDX_CNT_HI = 8'ha2;
	localparam logic [7:0] IDX_EVT_LO = 8'ha3;
	localparam logic [7:0] IDX_EVT_HI = 8'ha4;
	localparam logic [7:0] IDX_EVT_CTRL = 8'ha5;
	localparam logic [7:0] IDX_IRQ_CTRL = 8'ha6;
	localparam int ADDR_W = 12;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int BIT_RUN = 7;
	localparam int BIT_RATE_HI = 6;
	localparam int BIT_RATE_LO = 4;
	localparam int BIT_SRC = 3;
	localparam int BIT_START = 2;
	localparam int BIT_CMODE_HI = 1;
	localparam int BIT_CMODE_LO = 0;
	localparam int BIT_EVT_EN = 7;
	localparam int BIT_IRQ_FLAG = 0;
	localparam int BIT_IRQ_EN = 1;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [11:0] EVT_MAX = 12'hfff;
	localparam int PRESCALE_W = 7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CAP_OFF,
		CAP_HIGH,
		CAP_LOW,
		CAP_CYCLE
	} cap_mode_type;
	typedef enum {
		CAP_IDLE,
		CAP_ARM,
		CAP_COUNT
	} cap_state_type;
endpackage : capture_timer_pkg

// [verilog/capture_timer.sv]
// 16-bit up timer with prescaler, byte latches, capture and event counter
// Functional notes
// R1: Counter holds when disabled, advances when enabled
// R2: Increment per tick; wrap sets sticky overflow flag
// R3: No reload; continues from zero after overflow
// R4: Overflow with irq enable raises interrupt request
// R5: Counts in low-power modes; overflow issues wake-up
// R6: Rate field selects divide 128 down to 1
// R7: Capture mode: off, high, low, cycle
// R8: Source select: external pin or comparator
// R9: High byte write buffered; low write loads both
// R10: Low byte read snapshots high half
// R11: Software writes high first, reads low first
// R12: Software preloads 65536 minus interval ticks
// R13: Software configures mode before enabling timer
// R14: Capture needs enable set and start bit
// R15: Wait edge, count, stop, clear start, flag
// R16: Counter cleared when capture run starts
// R17: High mode: rise starts, fall stops
// R18: Low mode: fall starts, rise stops
// R19: Cycle mode: rise starts, next rise stops
// R20: Event counter overflow ends accumulated period
// R21: Event counter advances on source rising edges
// R22: Event enable only set while capture enabled
// R23: Capture input passes two-flop synchroniser
`timescale 1ns/1ps
module capture_timer
	import capture_timer_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic externalCapturePin,
	input wire logic comparatorOut,
	output logic overflowIrq,
	output logic wakeUp,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	function automatic logic [7:0] regIndex(input logic [ADDR_W-1:0] a);
		regIndex = a[9:2];
	endfunction : regIndex

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) && (regIndex(a) >= IDX_MODE)
			&& (regIndex(a) <= IDX_IRQ_CTRL);
	endfunction : mapped

	logic [7:0] mode;
	logic [15:0] count;
	logic [7:0] highBuf;
	logic [7:0] highSnap;
	logic [11:0] evtCount;
	logic [3:0] evtHighBuf;
	logic [3:0] evtHighSnap;
	logic evtEnable, overflowFlag, irqEnable;
	logic [PRESCALE_W-1:0] prescale;
	logic [2:0] syncCap;
	cap_state_type capState;
	logic awHeld, wHeld;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic writeFire, writeOk, readFire, wByte, tick;
	logic [7:0] wIdx;
	logic [7:0] rIdx;
	logic capSrc, riseEdge, fallEdge, startEdge, stopEdge;
	logic capMode, countStep, wrap, evtDone, capDone, startWrite;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign writeFire = awHeld && wHeld && !s_axi_bvalid;
	assign wIdx = regIndex(awAddr);
	assign writeOk = writeFire && mapped(awAddr);
	assign wByte = wStrb[0];

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wStrb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end else if (writeFire) begin
				awHeld <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end else if (writeFire) begin
				wHeld <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (writeFire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel
	assign s_axi_arready = !s_axi_rvalid;
	assign readFire = s_axi_arvalid && s_axi_arready;
	assign rIdx = regIndex(s_axi_araddr);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (readFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata <= '0;
			if (mapped(s_axi_araddr)) begin
				case (rIdx)
					IDX_MODE: s_axi_rdata[7:0] <= mode;
					IDX_CNT_LO: s_axi_rdata[7:0] <= count[7:0];
					IDX_CNT_HI: s_axi_rdata[7:0] <= highSnap;
					IDX_EVT_LO: s_axi_rdata[7:0] <= evtCount[7:0];
					IDX_EVT_HI: s_axi_rdata[3:0] <= evtHighSnap;
					IDX_EVT_CTRL: s_axi_rdata[BIT_EVT_EN] <= evtEnable;
					IDX_IRQ_CTRL: s_axi_rdata[1:0] <= {irqEnable, overflowFlag};
					default: s_axi_rdata <= '0;
				endcase
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Low byte read latches upper halves for a later high read
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			highSnap <= '0;
			evtHighSnap <= '0;
		end else if (readFire && mapped(s_axi_araddr)) begin
			if (rIdx == IDX_CNT_LO) begin
				highSnap <= count[15:8]; // R10
			end
			if (rIdx == IDX_EVT_LO) begin
				evtHighSnap <= evtCount[11:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and capture input
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			prescale <= '0;
		end else if (mode[BIT_RUN]) begin
			prescale <= prescale + PRESCALE_W'(1);
		end else begin
			prescale <= '0;
		end
	end

	always_comb begin
		case (mode[BIT_RATE_HI:BIT_RATE_LO]) // R6
			3'h0: tick = &prescale[6:0];
			3'h1: tick = &prescale[5:0];
			3'h2: tick = &prescale[4:0];
			3'h3: tick = &prescale[3:0];
			3'h4: tick = &prescale[2:0];
			3'h5: tick = &prescale[1:0];
			3'h6: tick = prescale[0];
			default: tick = 1'b1;
		endcase
	end

	assign capSrc = mode[BIT_SRC] ? comparatorOut : externalCapturePin; // R8
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			syncCap <= '0;
		end else begin
			syncCap <= {syncCap[1:0], capSrc}; // R23
		end
	end
	assign riseEdge = syncCap[1] && !syncCap[2];
	assign fallEdge = !syncCap[1] && syncCap[2];
	assign capMode = mode[BIT_CMODE_HI:BIT_CMODE_LO] != CAP_OFF;

	always_comb begin
		case (cap_mode_type'(mode[BIT_CMODE_HI:BIT_CMODE_LO])) // R7
			CAP_HIGH: begin
				startEdge = riseEdge; // R17
				stopEdge = fallEdge;
			end
			CAP_LOW: begin
				startEdge = fallEdge; // R18
				stopEdge = riseEdge;
			end
			CAP_CYCLE: begin
				startEdge = riseEdge; // R19
				stopEdge = riseEdge;
			end
			default: begin
				startEdge = 1'b0;
				stopEdge = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Capture sequencer
	assign startWrite = writeOk && wByte && wIdx == IDX_MODE && wData[BIT_START]
		&& !mode[BIT_START];
	assign evtDone = evtEnable && capState == CAP_COUNT && riseEdge && evtCount == EVT_MAX;
	assign capDone = capState == CAP_COUNT && (evtEnable ? evtDone : stopEdge); // R20
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			capState <= CAP_IDLE;
		end else begin
			case (capState)
				CAP_IDLE: if (startWrite && capMode && mode[BIT_RUN]) capState <= CAP_ARM; // R14
				CAP_ARM: if (!mode[BIT_START] || !mode[BIT_RUN]) capState <= CAP_IDLE;
					else if (startEdge) capState <= CAP_COUNT; // R15
				CAP_COUNT: if (capDone || !mode[BIT_START] || !mode[BIT_RUN]) capState <= CAP_IDLE;
				default: capState <= CAP_IDLE;
			endcase
		end
	end

	// Counting gate: free running in basic mode, windowed in capture mode
	assign countStep = mode[BIT_RUN] && tick && (!capMode || capState == CAP_COUNT); // R1
	assign wrap = countStep && count == COUNT_MAX;

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			mode <= MODE_RESET;
		end else if (writeOk && wByte && wIdx == IDX_MODE) begin
			mode <= wData[7:0];
		end else if (capDone) begin
			mode[BIT_START] <= 1'b0; // R15
		end
	end

	// High byte writes must not stall a running count
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			highBuf <= '0;
			count <= '0;
		end else begin
			if (writeOk && wByte && wIdx == IDX_CNT_HI) begin
				highBuf <= wData[7:0]; // R9
			end
			if (startWrite && capMode) begin
				count <= '0; // R16
			end else if (writeOk && wByte && wIdx == IDX_CNT_LO) begin
				count <= {highBuf, wData[7:0]}; // R9
			end else if (countStep) begin
				count <= count + 16'h0001; // R2 R3
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			evtHighBuf <= '0;
			evtCount <= '0;
		end else begin
			if (writeOk && wByte && wIdx == IDX_EVT_HI) begin
				evtHighBuf <= wData[3:0];
			end
			if (writeOk && wByte && wIdx == IDX_EVT_LO) begin
				evtCount <= {evtHighBuf, wData[7:0]};
			end else if (evtEnable && capState == CAP_COUNT && riseEdge) begin
				evtCount <= evtCount + 12'h001; // R21
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			evtEnable <= 1'b0;
		end else if (writeOk && wByte && wIdx == IDX_EVT_CTRL) begin
			evtEnable <= wData[BIT_EVT_EN] && capMode; // R22
		end
	end

	// Hardware set beats a same-cycle software clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			overflowFlag <= 1'b0;
			irqEnable <= 1'b0;
		end else begin
			if (wrap || capDone) begin
				overflowFlag <= 1'b1; // R2 R15
			end else if (writeOk && wByte && wIdx == IDX_IRQ_CTRL) begin
				overflowFlag <= wData[BIT_IRQ_FLAG];
			end
			if (writeOk && wByte && wIdx == IDX_IRQ_CTRL) begin
				irqEnable <= wData[BIT_IRQ_EN];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wakeUp <= 1'b0;
		end else begin
			wakeUp <= wrap || capDone; // R5
		end
	end
	assign overflowIrq = overflowFlag && irqEnable; // R4

endmodule : capture_timer

// [verification/capture_timer_asserts.sv]
// Port assertions for the capture timer
`timescale 1ns/1ps
module capture_timer_asserts
	import capture_timer_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic overflowIrq,
	input wire logic wakeUp,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_reset_quiet: assert property (disable iff (1'h0) !nrst |=>
		!s_axi_bvalid && !s_axi_rvalid && !wakeUp && !overflowIrq) else $error("busy after reset");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_wake_pulse: assert property (wakeUp |=> !wakeUp) else $error("wake too long");
	a_irq_wake: assert property ($rose(overflowIrq) |-> ##[0:2] wakeUp)
		else $error("no wake on overflow");
	a_flag_sticky: assert property (overflowIrq && !s_axi_awvalid && !$past(s_axi_awvalid)
		&& !$past(s_axi_awvalid, 2) |=> overflowIrq) else $error("flag lost");
endmodule : capture_timer_asserts
bind capture_timer capture_timer_asserts capture_timer_asserts_inst (.sys_clk, .nrst,
	.overflowIrq, .wakeUp, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// [verification/capture_source_model.sv]
// Square-wave source standing in for the measured pin or comparator
`timescale 1ns/1ps
module capture_source_model (
	input wire logic sys_clk,
	input wire logic [7:0] highLen,
	input wire logic [7:0] lowLen,
	output logic level
);
	logic [7:0] phase = 8'h00;
	initial level = 1'h0;
	always @(posedge sys_clk) begin
		phase <= phase + 8'h01;
		if (phase + 8'h01 >= (level ? highLen : lowLen)) begin
			level <= !level;
			phase <= 8'h00;
		end
	end
endmodule : capture_source_model

// [verification/capture_timer_test.sv]
// Self-checking bench for the capture timer
`timescale 1ns/1ps
module capture_timer_test;
	import capture_timer_pkg::*;
	typedef struct {logic [31:0] lo; logic [31:0] hi; logic [1:0] resp;} note_type;
	note_type notes[$];
	note_type cur;
	logic sys_clk = 1'h0;
	logic nrst = 1'h0;
	logic [1:0] level;
	logic [1:0][7:0] hiLen = 16'h1010;
	logic [1:0][7:0] loLen = 16'h1010;
	logic overflowIrq, wakeUp, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [ADDR_W-1:0] s_axi_awaddr = '0;
	logic [ADDR_W-1:0] s_axi_araddr = '0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	capture_timer capture_timer_inst (.sys_clk, .nrst, .externalCapturePin(level[0]),
		.comparatorOut(level[1]), .overflowIrq, .wakeUp, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1));
	capture_source_model capture_source_model_inst[1:0] (.sys_clk, .highLen(hiLen),
		.lowLen(loLen), .level);
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk) if (s_axi_bvalid || s_axi_rvalid) begin
		check_count++;
		if (notes.size() == 0) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time,
				{s_axi_bvalid, s_axi_rvalid}, 2'h0);
		end else begin
			cur = notes.pop_front();
			if (s_axi_bvalid ? s_axi_bresp !== cur.resp : s_axi_rresp !== cur.resp ||
				(s_axi_rdata >= cur.lo && s_axi_rdata <= cur.hi) !== 1'h1) begin
				fail_count++;
				$display("mismatch at %0t got %h/%h expected %h/%h", $time, s_axi_rdata,
					s_axi_bvalid ? s_axi_bresp : s_axi_rresp, cur.lo, cur.resp);
			end
		end
	end
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
		notes.push_back('{32'h0, 32'h0, r});
		s_axi_awaddr <= {2'h0, idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		while (!s_axi_bvalid) @(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi,
		input logic [1:0] r = RESP_OKAY);
		notes.push_back('{lo, hi, r});
		s_axi_araddr <= {2'h0, idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
	endtask : rd
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] h, l;
		logic [31:0] e;
		void'($urandom(820));
		repeat (6) @(posedge sys_clk);
		nrst <= 1'h1;
		@(posedge sys_clk);
		rd(IDX_MODE, 32'h0, 32'h0);
		rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
		wr(8'h40, 8'h55, RESP_SLVERR);
		wr(IDX_CNT_HI, 8'h12);
		rd(IDX_CNT_LO, 32'h0, 32'h0);
		rd(IDX_CNT_HI, 32'h0, 32'h0);
		wr(IDX_CNT_LO, 8'h34);
		repeat (20) @(posedge sys_clk);
		rd(IDX_CNT_LO, 32'h34, 32'h34);
		rd(IDX_CNT_HI, 32'h12, 32'h12);
		// Wrap from near full scale at divide by one
		wr(IDX_IRQ_CTRL, 8'h02);
		wr(IDX_CNT_HI, 8'hff);
		wr(IDX_CNT_LO, 8'hf0);
		wr(IDX_MODE, 8'h70);
		wr(IDX_MODE, 8'hf0);
		while (overflowIrq !== 1'h1) @(posedge sys_clk);
		wr(IDX_MODE, 8'h70);
		rd(IDX_IRQ_CTRL, 32'h3, 32'h3);
		rd(IDX_CNT_LO, 32'h0, 32'h40);
		rd(IDX_CNT_HI, 32'h0, 32'h0);
		wr(IDX_IRQ_CTRL, 8'h02);
		rd(IDX_IRQ_CTRL, 32'h2, 32'h2);
		for (int k = 0; k < 8; k++) begin
			wr(IDX_CNT_HI, 8'h00);
			wr(IDX_CNT_LO, 8'h00);
			wr(IDX_MODE, {1'h0, k[2:0], 4'h0});
			wr(IDX_MODE, {1'h1, k[2:0], 4'h0});
			repeat (240) @(posedge sys_clk);
			wr(IDX_MODE, {1'h0, k[2:0], 4'h0});
			rd(IDX_CNT_LO, (240 >> (7 - k)) - 1, (246 >> (7 - k)) + 1);
			rd(IDX_CNT_HI, 32'h0, 32'h0);
		end
		for (int s = 0; s < 2; s++)
			for (int m = 1; m < 4; m++) begin
				h = 8'h08 + 8'($urandom % 100);
				l = 8'h08 + 8'($urandom % 100);
				hiLen[s] <= h;
				loLen[s] <= l;
				e = (m == 1) ? 32'(h) : (m == 2) ? 32'(l) : 32'(h) + 32'(l);
				wr(IDX_MODE, {1'h0, 3'h7, s[0], 1'h0, m[1:0]});
				wr(IDX_MODE, {1'h1, 3'h7, s[0], 1'h0, m[1:0]});
				wr(IDX_MODE, {1'h1, 3'h7, s[0], 1'h1, m[1:0]});
				while (overflowIrq !== 1'h1) @(posedge sys_clk);
				rd(IDX_MODE, {24'h0, 1'h1, 3'h7, s[0], 1'h0, m[1:0]},
					{24'h0, 1'h1, 3'h7, s[0], 1'h0, m[1:0]});
				rd(IDX_CNT_LO, e - 1, e + 1);
				rd(IDX_CNT_HI, 32'h0, 32'h0);
				wr(IDX_IRQ_CTRL, 8'h02);
				wr(IDX_MODE, 8'h00);
			end
		// Event counter: refused without capture mode, then three whole periods
		wr(IDX_EVT_CTRL, 8'h80);
		rd(IDX_EVT_CTRL, 32'h0, 32'h0);
		h = 8'h08 + 8'($urandom % 30);
		l = 8'h08 + 8'($urandom % 30);
		hiLen[0] <= h;
		loLen[0] <= l;
		e = 32'h3 * (32'(h) + 32'(l));
		wr(IDX_MODE, 8'h73);
		wr(IDX_EVT_HI, 8'h0f);
		wr(IDX_EVT_LO, 8'hfd);
		rd(IDX_EVT_LO, 32'hfd, 32'hfd);
		rd(IDX_EVT_HI, 32'h0f, 32'h0f);
		wr(IDX_EVT_CTRL, 8'h80);
		rd(IDX_EVT_CTRL, 32'h80, 32'h80);
		wr(IDX_MODE, 8'hf3);
		wr(IDX_MODE, 8'hf7);
		while (overflowIrq !== 1'h1) @(posedge sys_clk);
		rd(IDX_CNT_LO, e - 1, e + 1);
		rd(IDX_CNT_HI, 32'h0, 32'h0);
		rd(IDX_EVT_LO, 32'h0, 32'h0);
		rd(IDX_EVT_HI, 32'h0, 32'h0);
		stop_test();
	end
endmodule : capture_timer_test
